// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import tsq_pkg::*;
;
  logic CLK_IN = 1'b0;
  logic RST_B_IN = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_CH-1:0] lvl = '0;
  logic [LBITS-1:0] lbits = '0;
  logic slow = 1'b0;
  tsq_probe_s probe;
  logic trig, cap, armed;
  logic [6:0] pos;
  logic [REC_W-1:0] pretrig;
  int bad_count = 0;
  int tests_run = 0;
  // register defaults after reset, last entry is an unmapped place
  logic [ADDR_W-1:0] ra [6] = '{ADR_HOLD, ADR_DELAY, ADR_POS, ADR_COUNT, ADR_REC, 8'h30};
  logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0032, 32'h0000_0001,
                          32'h0000_03E8, 32'h0000_0000};

  // 100 MHz clock
  always #5 CLK_IN = ~CLK_IN;

  tsq_probe_model tsq_probe_model_i (.clk_in(CLK_IN), .above_in(lvl), .bits_in(lbits),
    .slow_in(slow), .probe_out(probe));

  tsq_sequencer tsq_sequencer_i (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr_stb), .RD_IN(rd_stb), .RDATA_OUT(rdata), .PROBE_IN(probe),
    .TRIG_OUT(trig), .CAPTURE_OUT(cap), .ARMED_OUT(armed), .POS_OUT(pos),
    .PRETRIG_OUT(pretrig));

  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge CLK_IN);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the read edge
  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge CLK_IN);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge CLK_IN);
    rd_stb <= 1'b0;
    #1;
    chk(name, e, rdata);
  endtask : rd_chk

  // cycles from now to the first trigger and capture pulse, -1 if none
  task automatic mon(input int lim, output int t, output int c);
    t = -1;
    c = -1;
    for (int i = 1; i <= lim; i++) begin
      @(posedge CLK_IN);
      #1;
      if (trig === 1'b1 && t < 0) t = i;
      if (cap === 1'b1 && c < 0) c = i;
    end
  endtask : mon

  // move the inputs, then judge whether a trigger follows
  task automatic step(input logic [7:0] a, input logic [7:0] b, input logic fire);
    int t;
    int c;
    @(posedge CLK_IN);
    lvl <= a;
    lbits <= b;
    mon(8, t, c);
    chk("trigger", 32'(fire), 32'(t > 0));
    if (fire) chk("capture", t, c);
  endtask : step

  function automatic logic [31:0] ctl(logic seq, logic [1:0] sl, logic [2:0] src, logic lg,
                                      logic [2:0] b, logic ax);
    logic [31:0] v;
    v = 32'h0000_0001;
    v[CTL_SEQ] = seq;
    v[CTL_SLOPE+:2] = sl;
    v[CTL_SRC+:3] = src;
    v[CTL_SRC_LOGIC] = lg;
    v[CTL_BIT+:3] = b;
    v[CTL_A_EXIT] = ax;
    return v;
  endfunction : ctl

  // halt first so that position and pre-trigger share are latched afresh
  task automatic arm(input logic [31:0] v);
    wr(ADR_CTRL, 32'h0000_0000);
    wr(ADR_CTRL, v);
    repeat (4) @(posedge CLK_IN);
    chk("armed", 32'h0000_0001, 32'(armed));
  endtask : arm

  // a hang ends the run as a failure
  initial begin
    repeat (60000) @(posedge CLK_IN);
    bad_count++;
    summarize;
  end

  initial begin
    int t;
    int c;
    int ch;
    int b;
    logic [15:0] r;
    logic [6:0] p;
    logic [6:0] q;
    void'($urandom(32'h1b07));
    repeat (2) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    #1;
    chk("pos after reset", 32'h0000_0032, pos);
    foreach (ra[i]) rd_chk("register default", ra[i], rv[i]);
    // every slope code on a random channel, comparator speed random
    for (int s = 0; s < 4; s++) begin
      ch = $urandom_range(NUM_CH - 1);
      slow <= 1'($urandom);
      arm(ctl(1'b0, 2'(s), 3'(ch), 1'b0, 3'h0, 1'b0));
      step(8'(1 << ((ch + 1) % 8)), 8'h00, 1'b0);
      step(8'(1 << ch), 8'h00, s[0]);
      step(8'h00, 8'h00, s[1]);
    end
    slow <= 1'b0;
    // logic bit source: only the chosen bit counts
    b = $urandom_range(LBITS - 1);
    arm(ctl(1'b0, SLOPE_RISE, 3'h0, 1'b1, 3'(b), 1'b0));
    step(8'h00, ~8'(1 << b), 1'b0);
    step(8'h00, 8'hFF, 1'b1);
    step(8'h00, 8'h00, 1'b0);
    // holdoff of two ticks suppresses edges, then frees them; kept far below the long range
    wr(ADR_HOLD, 32'h0000_0002);
    arm(ctl(1'b0, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    step(8'h01, 8'h00, 1'b1);
    chk("armed in holdoff", 32'h0000_0000, 32'(armed));
    step(8'h00, 8'h00, 1'b0);
    step(8'h01, 8'h00, 1'b0);
    repeat (55) @(posedge CLK_IN);
    step(8'h00, 8'h00, 1'b0);
    step(8'h01, 8'h00, 1'b0);
    step(8'h00, 8'h00, 1'b0);
    chk("armed after holdoff", 32'h0000_0001, 32'(armed));
    step(8'h01, 8'h00, 1'b1);
    wr(ADR_HOLD, 32'h0000_0000);
    // capture two ticks after the trigger
    wr(ADR_DELAY, 32'h0000_0002);
    arm(ctl(1'b0, SLOPE_FALL, 3'h0, 1'b0, 3'h0, 1'b0));
    @(posedge CLK_IN);
    lvl <= 8'h00;
    mon(120, t, c);
    chk("delay", 32'h0000_0064, 32'(c - t));
    wr(ADR_DELAY, 32'h0000_0000);
    // position and pre-trigger share per record
    r = 16'($urandom);
    p = 7'($urandom_range(100));
    q = 7'(100 - p);
    wr(ADR_REC, 32'(r));
    wr(ADR_POS, 32'(p));
    arm(ctl(1'b0, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    chk("pos", 32'(p), 32'(pos));
    chk("pretrig", (32'(r) * 32'(p)) / 100, 32'(pretrig));
    wr(ADR_CTRL, 32'h0000_0000);
    wr(ADR_POS, 32'(q));
    repeat (4) @(posedge CLK_IN);
    chk("pos halted", 32'(p), 32'(pos));
    arm(ctl(1'b0, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    chk("pos rearmed", 32'(q), 32'(pos));
    wr(ADR_POS, 32'h0000_00C8);
    rd_chk("pos clamp", ADR_POS, 32'h0000_0064);
    wr(ADR_CTRL, 32'h0000_0004);
    rd_chk("pos reset", ADR_POS, 32'h0000_0032);
    wr(ADR_COUNT, 32'h0000_0000);
    rd_chk("count zero", ADR_COUNT, 32'h0000_0001);
    wr(ADR_COUNT, 32'h0000_00FF);
    rd_chk("count max", ADR_COUNT, 32'h0000_00FF);
    wr(ADR_CTRL, 32'h0000_0008);
    rd_chk("count reset", ADR_COUNT, 32'h0000_0001);
    // A on ch1 above, B on ch2 above, third B entry fires, twice over
    wr(ADR_COUNT, 32'h0000_0003);
    wr(ADR_PAT_A, 32'h0000_0004);
    wr(ADR_PAT_B, 32'h0000_0010);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    for (int k = 0; k < 2; k++) begin
      step(8'h04, 8'h00, 1'b0);
      step(8'h00, 8'h00, 1'b0);
      step(8'h02, 8'h00, 1'b0);
      step(8'h06, 8'h00, 1'b0);
      step(8'h02, 8'h00, 1'b0);
      step(8'h06, 8'h00, 1'b0);
      step(8'h02, 8'h00, 1'b0);
      step(8'h06, 8'h00, 1'b1);
      step(8'h00, 8'h00, 1'b0);
    end
    // exit mode on B: the first time B is left fires
    wr(ADR_COUNT, 32'h0000_0001);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0) | (32'h0000_0001 << CTL_B_EXIT));
    step(8'h02, 8'h00, 1'b0);
    step(8'h06, 8'h00, 1'b0);
    step(8'h02, 8'h00, 1'b1);
    // eleven triggers so far, sequencer armed again
    rd_chk("status", ADR_STAT, 32'h000B_0002);
    // single pattern: ch3 below, entry then exit mode
    wr(ADR_COUNT, 32'h0000_0001);
    wr(ADR_PAT_B, 32'h0000_0000);
    wr(ADR_PAT_A, 32'h0000_0080);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    step(8'h08, 8'h00, 1'b0);
    step(8'h00, 8'h00, 1'b1);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b1));
    step(8'h08, 8'h00, 1'b1);
    step(8'h00, 8'h00, 1'b0);
    // logic channel only: bits 3..0 must read 0101
    wr(ADR_PAT_A, 32'h0000_0000);
    wr(ADR_LOGIC, 32'h0001_050F);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    step(8'h00, 8'h04, 1'b0);
    step(8'h00, 8'h05, 1'b1);
    step(8'h00, 8'h00, 1'b0);
    // nothing selected in A never fires
    wr(ADR_LOGIC, 32'h0000_0000);
    arm(ctl(1'b1, SLOPE_RISE, 3'h0, 1'b0, 3'h0, 1'b0));
    step(8'hFF, 8'hFF, 1'b0);
    step(8'h00, 8'h00, 1'b0);
    summarize;
  end
endmodule : tb_top

// ### bench/tsq_probe_model.sv
`timescale 1ns/1ps
// stand-in for the channel comparators and the logic probe
module tsq_probe_model
  import tsq_pkg::*;
(
  // clock
  input wire logic clk_in,
  // levels at the channel inputs, one flag per channel above its level
  input wire logic [NUM_CH-1:0] above_in,
  input wire logic [LBITS-1:0] bits_in,
  input wire logic slow_in,
  // comparator outputs
  output tsq_probe_s probe_out
);
  tsq_probe_s late;

  // one extra stage, as a sluggish comparator would show
  always_ff @(posedge clk_in) begin
    late <= '{above: above_in, bits: bits_in};
  end

  // the programmed level is the threshold between the above and below states
  assign probe_out = slow_in ? late : tsq_probe_s'{above: above_in, bits: bits_in};
endmodule : tsq_probe_model

// ### hdl/tsq_pkg.sv
package tsq_pkg;

  // clock and timing tick
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_NS = 500;
  localparam int unsigned TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int unsigned TIME_MAX_NS = 1_000_000_000;
  localparam int unsigned TIME_W = 21;
  localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(TIME_MAX_NS / TICK_NS);
  localparam logic [TIME_W-1:0] TIME_ZERO = 21'h00_0000;
  localparam logic [TIME_W-1:0] TIME_ONE = 21'h00_0001;

  // sizes
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned LBITS = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REC_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_HOLD = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_POS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADR_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_PAT_A = 8'h14;
  localparam logic [ADDR_W-1:0] ADR_PAT_B = 8'h18;
  localparam logic [ADDR_W-1:0] ADR_LOGIC = 8'h1C;
  localparam logic [ADDR_W-1:0] ADR_REC = 8'h20;
  localparam logic [ADDR_W-1:0] ADR_STAT = 8'h24;

  // control, logic and status register fields
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_SEQ = 1;
  localparam int unsigned CTL_POS_RST = 2;
  localparam int unsigned CTL_CNT_RST = 3;
  localparam int unsigned CTL_SLOPE = 4;
  localparam int unsigned CTL_SRC = 6;
  localparam int unsigned CTL_SRC_LOGIC = 9;
  localparam int unsigned CTL_BIT = 10;
  localparam int unsigned CTL_A_EXIT = 13;
  localparam int unsigned CTL_B_EXIT = 14;
  localparam int unsigned LOG_VAL = 8;
  localparam int unsigned LOG_EN = 16;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_CNT = 16;

  // encodings
  localparam logic [1:0] SLOPE_RISE = 2'h1;
  localparam logic [1:0] SLOPE_FALL = 2'h2;
  localparam logic [1:0] PS_HI = 2'h1;
  localparam logic [1:0] PS_LO = 2'h2;

  // reset values and limits
  localparam logic [6:0] POS_DEF = 7'h32;
  localparam logic [6:0] POS_MAX = 7'h64;
  localparam logic [7:0] CNT_DEF = 8'h01;
  localparam logic [REC_W-1:0] REC_DEF = 16'h03E8;
  localparam logic [22:0] PCT_FULL = 23'h00_0064;

  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_ARM, S_B} tsq_state_e;

  // comparator outputs and logic probe bits
  typedef struct packed {
    logic [NUM_CH-1:0] above;
    logic [LBITS-1:0] bits;
  } tsq_probe_s;

  typedef struct packed {
    logic run;
    logic seq_mode;
    logic [1:0] slope;
    logic [2:0] src;
    logic src_logic;
    logic [2:0] bit_sel;
    logic a_exit;
    logic b_exit;
    logic [TIME_W-1:0] holdoff;
    logic [TIME_W-1:0] delay;
    logic [6:0] pos_req;
    logic [7:0] count_n;
    logic [2*NUM_CH-1:0] pat_a;
    logic [2*NUM_CH-1:0] pat_b;
    logic [LBITS-1:0] lmask;
    logic [LBITS-1:0] lval;
    logic lena;
    logic [REC_W-1:0] rec_len;
  } tsq_cfg_s;

endpackage : tsq_pkg

// ### hdl/tsq_sequencer.sv
`timescale 1ns/1ps
module tsq_sequencer
  import tsq_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [DATA_W-1:0] RDATA_OUT,
  // channel comparators and logic probe
  input wire tsq_probe_s PROBE_IN,
  // acquisition memory controller side
  output logic TRIG_OUT,
  output logic CAPTURE_OUT,
  output logic ARMED_OUT,
  output logic [6:0] POS_OUT,
  output logic [REC_W-1:0] PRETRIG_OUT
);

  typedef struct packed {
    tsq_cfg_s cfg;
    tsq_probe_s sync1;
    tsq_probe_s sync2;
    tsq_probe_s prev;
    logic prev_a;
    logic prev_b;
    tsq_state_e state;
    logic [TICK_W-1:0] tick_cnt;
    logic [TIME_W-1:0] hold_cnt;
    logic [TIME_W-1:0] delay_cnt;
    logic delay_busy;
    logic [7:0] b_cnt;
    logic [6:0] pos_act;
    logic [REC_W-1:0] pretrig;
    logic [15:0] trig_count;
    logic [DATA_W-1:0] rdata;
    logic trig;
    logic cap;
    logic armed;
  } tsq_regs_s;

  tsq_regs_s q;
  tsq_regs_s next_q;

  // time settings saturate at one second rather than wrap
  function automatic logic [TIME_W-1:0] clamp_time(input logic [DATA_W-1:0] v);
    if (v > DATA_W'(TIME_MAX)) begin
      clamp_time = TIME_MAX;
    end else begin
      clamp_time = v[TIME_W-1:0];
    end
  endfunction : clamp_time

  // every non-ignored channel must sit on its programmed side
  function automatic logic pat_match(input logic [2*NUM_CH-1:0] pat,
                                     input logic [NUM_CH-1:0] above);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pat[2*i +: 2] == PS_HI && !above[i]) begin
        ok = 1'b0;
      end else if (pat[2*i +: 2] == PS_LO && above[i]) begin
        ok = 1'b0;
      end
    end
    pat_match = ok;
  endfunction : pat_match

  // true when at least one channel is not ignored
  function automatic logic pat_care(input logic [2*NUM_CH-1:0] pat);
    logic any;
    any = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pat[2*i +: 2] == PS_HI || pat[2*i +: 2] == PS_LO) begin
        any = 1'b1;
      end
    end
    pat_care = any;
  endfunction : pat_care

  // pattern and edge qualification on synchronised inputs
  logic a_care;
  logic b_care;
  logic logic_ok;
  logic match_a;
  logic match_b;
  logic ev_a;
  logic ev_b;
  logic lvl_now;
  logic lvl_prev;
  logic ev_edge;
  logic tick;
  logic [22:0] pos_prod;

  assign a_care = pat_care(q.cfg.pat_a) | q.cfg.lena;
  assign b_care = pat_care(q.cfg.pat_b);
  // logic probe counts only in the first pattern, as an AND of cared bits
  assign logic_ok = !q.cfg.lena ||
                    ((q.sync2.bits & q.cfg.lmask) == (q.cfg.lval & q.cfg.lmask));
  // comparator bit is the channel level threshold
  assign match_a = a_care && logic_ok && pat_match(q.cfg.pat_a, q.sync2.above);
  assign match_b = pat_match(q.cfg.pat_b, q.sync2.above);
  // entry fires on becoming true, exit on leaving it
  assign ev_a = q.cfg.a_exit ? (!match_a && q.prev_a && a_care) : (match_a && !q.prev_a);
  assign ev_b = q.cfg.b_exit ? (!match_b && q.prev_b) : (match_b && !q.prev_b);
  // edge source is an analog comparator or one chosen logic bit
  assign lvl_now = q.cfg.src_logic ? q.sync2.bits[q.cfg.bit_sel] : q.sync2.above[q.cfg.src];
  assign lvl_prev = q.cfg.src_logic ? q.prev.bits[q.cfg.bit_sel] : q.prev.above[q.cfg.src];
  assign ev_edge = (q.cfg.slope[0] && lvl_now && !lvl_prev) ||
                   (q.cfg.slope[1] && !lvl_now && lvl_prev);
  assign tick = (q.tick_cnt == TICK_LAST);
  assign pos_prod = 23'(q.cfg.rec_len * q.cfg.pos_req);

  // next state: bus, synchronisers, sequencer and timers
  always_comb begin
    logic fire;
    fire = 1'b0;
    next_q = q;
    next_q.trig = 1'b0;
    next_q.cap = 1'b0;
    next_q.rdata = '0;
    // two stages before any logic looks at the pins
    next_q.sync1 = PROBE_IN;
    next_q.sync2 = q.sync1;
    next_q.prev = q.sync2;
    next_q.prev_a = match_a;
    next_q.prev_b = match_b;
    next_q.tick_cnt = tick ? '0 : TICK_W'(q.tick_cnt + 1'b1);

    // register writes
    if (WR_IN) begin
      if (ADDR_IN == ADR_CTRL) begin
        next_q.cfg.run = WDATA_IN[CTL_RUN];
        next_q.cfg.seq_mode = WDATA_IN[CTL_SEQ];
        next_q.cfg.slope = WDATA_IN[CTL_SLOPE +: 2];
        next_q.cfg.src = WDATA_IN[CTL_SRC +: 3];
        next_q.cfg.src_logic = WDATA_IN[CTL_SRC_LOGIC];
        next_q.cfg.bit_sel = WDATA_IN[CTL_BIT +: 3];
        next_q.cfg.a_exit = WDATA_IN[CTL_A_EXIT];
        next_q.cfg.b_exit = WDATA_IN[CTL_B_EXIT];
        if (WDATA_IN[CTL_POS_RST]) begin
          next_q.cfg.pos_req = POS_DEF;
        end
        if (WDATA_IN[CTL_CNT_RST]) begin
          next_q.cfg.count_n = CNT_DEF;
        end
      end else if (ADDR_IN == ADR_HOLD) begin
        next_q.cfg.holdoff = clamp_time(WDATA_IN);
      end else if (ADDR_IN == ADR_DELAY) begin
        // only this write moves the delay; no timebase setting reaches it
        next_q.cfg.delay = clamp_time(WDATA_IN);
      end else if (ADDR_IN == ADR_POS) begin
        if (WDATA_IN > DATA_W'(POS_MAX)) begin
          next_q.cfg.pos_req = POS_MAX;
        end else begin
          next_q.cfg.pos_req = WDATA_IN[6:0];
        end
      end else if (ADDR_IN == ADR_COUNT) begin
        // zero is not a count; keep the lowest legal one
        next_q.cfg.count_n = (WDATA_IN[7:0] == 8'h00) ? CNT_DEF : WDATA_IN[7:0];
      end else if (ADDR_IN == ADR_PAT_A) begin
        next_q.cfg.pat_a = WDATA_IN[2*NUM_CH-1:0];
      end else if (ADDR_IN == ADR_PAT_B) begin
        next_q.cfg.pat_b = WDATA_IN[2*NUM_CH-1:0];
      end else if (ADDR_IN == ADR_LOGIC) begin
        next_q.cfg.lmask = WDATA_IN[LBITS-1:0];
        next_q.cfg.lval = WDATA_IN[LOG_VAL +: LBITS];
        next_q.cfg.lena = WDATA_IN[LOG_EN];
      end else if (ADDR_IN == ADR_REC) begin
        next_q.cfg.rec_len = WDATA_IN[REC_W-1:0];
      end
    end

    // register reads, answered in the following cycle
    if (RD_IN) begin
      if (ADDR_IN == ADR_CTRL) begin
        next_q.rdata[CTL_RUN] = q.cfg.run;
        next_q.rdata[CTL_SEQ] = q.cfg.seq_mode;
        next_q.rdata[CTL_SLOPE +: 2] = q.cfg.slope;
        next_q.rdata[CTL_SRC +: 3] = q.cfg.src;
        next_q.rdata[CTL_SRC_LOGIC] = q.cfg.src_logic;
        next_q.rdata[CTL_BIT +: 3] = q.cfg.bit_sel;
        next_q.rdata[CTL_A_EXIT] = q.cfg.a_exit;
        next_q.rdata[CTL_B_EXIT] = q.cfg.b_exit;
      end else if (ADDR_IN == ADR_HOLD) begin
        next_q.rdata[TIME_W-1:0] = q.cfg.holdoff;
      end else if (ADDR_IN == ADR_DELAY) begin
        next_q.rdata[TIME_W-1:0] = q.cfg.delay;
      end else if (ADDR_IN == ADR_POS) begin
        next_q.rdata[6:0] = q.cfg.pos_req;
      end else if (ADDR_IN == ADR_COUNT) begin
        next_q.rdata[7:0] = q.cfg.count_n;
      end else if (ADDR_IN == ADR_PAT_A) begin
        next_q.rdata[2*NUM_CH-1:0] = q.cfg.pat_a;
      end else if (ADDR_IN == ADR_PAT_B) begin
        next_q.rdata[2*NUM_CH-1:0] = q.cfg.pat_b;
      end else if (ADDR_IN == ADR_LOGIC) begin
        next_q.rdata[LBITS-1:0] = q.cfg.lmask;
        next_q.rdata[LOG_VAL +: LBITS] = q.cfg.lval;
        next_q.rdata[LOG_EN] = q.cfg.lena;
      end else if (ADDR_IN == ADR_REC) begin
        next_q.rdata[REC_W-1:0] = q.cfg.rec_len;
      end else if (ADDR_IN == ADR_STAT) begin
        next_q.rdata[1:0] = q.state;
        next_q.rdata[STAT_BUSY] = q.delay_busy;
        next_q.rdata[STAT_CNT +: 16] = q.trig_count;
      end
    end

    // trigger sequencer
    case (q.state)
      S_IDLE: begin
        if (q.cfg.run) begin
          next_q.state = S_HOLD;
          next_q.hold_cnt = TIME_ZERO;
        end
      end
      S_HOLD: begin
        // conditions are not looked at here, so nothing can fire
        if (q.hold_cnt == TIME_ZERO) begin
          next_q.state = S_ARM;
          // a fresh record picks up the requested position
          next_q.pos_act = q.cfg.pos_req;
          next_q.pretrig = REC_W'(pos_prod / PCT_FULL);
          next_q.b_cnt = 8'h00;
        end else if (tick) begin
          next_q.hold_cnt = TIME_W'(q.hold_cnt - TIME_ONE);
        end
      end
      S_ARM: begin
        if (!q.cfg.seq_mode) begin
          fire = ev_edge;
        end else if (ev_a) begin
          if (!b_care) begin
            fire = 1'b1;
          end else begin
            next_q.state = S_B;
            next_q.b_cnt = 8'h00;
          end
        end
      end
      S_B: begin
        // holdoff has already expired; second pattern counts freely
        if (ev_b) begin
          if (8'(q.b_cnt + 8'h01) == q.cfg.count_n) begin
            fire = 1'b1;
          end else begin
            next_q.b_cnt = 8'(q.b_cnt + 8'h01);
          end
        end
      end
      default: begin
        next_q.state = S_IDLE;
      end
    endcase

    // post-trigger delay runs in ticks aligned to the trigger
    if (q.delay_busy && tick) begin
      next_q.delay_cnt = TIME_W'(q.delay_cnt - TIME_ONE);
      if (q.delay_cnt == TIME_ONE) begin
        next_q.delay_busy = 1'b0;
        next_q.cap = 1'b1;
      end
    end

    // issue trigger, restart holdoff and the delay from this sample
    if (fire) begin
      next_q.trig = 1'b1;
      next_q.trig_count = 16'(q.trig_count + 16'h0001);
      next_q.state = S_HOLD;
      next_q.hold_cnt = q.cfg.holdoff;
      next_q.tick_cnt = '0;
      if (q.cfg.delay == TIME_ZERO) begin
        next_q.cap = 1'b1;
        next_q.delay_busy = 1'b0;
      end else begin
        next_q.delay_busy = 1'b1;
        next_q.delay_cnt = q.cfg.delay;
      end
    end

    // halting returns to idle and drops a pending delay, trigger and capture; settings, trigger count and position stay
    if (!q.cfg.run) begin
      next_q.state = S_IDLE;
      next_q.delay_busy = 1'b0;
      next_q.trig = 1'b0;
      next_q.cap = 1'b0;
    end
    // armed taken from the settled next state so the pin comes off a flop
    next_q.armed = (next_q.state == S_ARM) || (next_q.state == S_B);
  end

  // state register, synchronous active-low reset
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      q <= '0;
      q.state <= S_IDLE;
      q.cfg.slope <= SLOPE_RISE;
      q.cfg.holdoff <= TIME_ZERO;
      q.cfg.pos_req <= POS_DEF;
      q.cfg.count_n <= CNT_DEF;
      q.cfg.rec_len <= REC_DEF;
      q.pos_act <= POS_DEF;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign RDATA_OUT = q.rdata;
  assign TRIG_OUT = q.trig;
  assign CAPTURE_OUT = q.cap;
  assign ARMED_OUT = q.armed;
  assign POS_OUT = q.pos_act;
  assign PRETRIG_OUT = q.pretrig;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  sequence last_b_seq;
    q.state == S_B && ev_b && (8'(q.b_cnt + 8'h01) == q.cfg.count_n) && q.cfg.run;
  endsequence

  sequence enter_b_seq;
    $past(q.state) != S_B && q.state == S_B;
  endsequence

  holdoff_quiet_a: assert property ((q.state == S_HOLD) |=> !q.trig)
    else $error("trigger issued during holdoff");
  holdoff_load_a: assert property (q.trig |-> q.state == S_HOLD &&
                                   q.hold_cnt == $past(q.cfg.holdoff))
    else $error("holdoff not restarted at trigger");
  holdoff_step_a: assert property ((q.state == S_HOLD && q.hold_cnt != TIME_ZERO &&
                                    tick && q.cfg.run) |=>
                                   q.hold_cnt == $past(q.hold_cnt) - TIME_ONE)
    else $error("holdoff did not count one tick");
  tick_gap_a: assert property ((tick && !next_q.trig) |=> !tick [*8])
    else $error("tick repeated too soon");
  delay_zero_a: assert property ((q.trig && $past(q.cfg.delay) == TIME_ZERO) |-> q.cap)
    else $error("zero delay capture missing");
  pos_latch_a: assert property ($changed(q.pos_act) |-> q.state == S_ARM &&
                                $past(q.state) == S_HOLD)
    else $error("position changed outside record start");
  pos_range_a: assert property (q.cfg.pos_req <= POS_MAX)
    else $error("position above full record");
  count_range_a: assert property (q.cfg.count_n != 8'h00)
    else $error("occurrence count is zero");
  a_ignored_a: assert property ((q.state == S_ARM && q.cfg.seq_mode && !a_care) |=>
                                !q.trig && q.state != S_B)
    else $error("ignored first pattern fired");
  nth_fire_a: assert property (last_b_seq |=> q.trig)
    else $error("n-th second pattern did not fire");
  b_clear_a: assert property (enter_b_seq |-> q.b_cnt == 8'h00)
    else $error("occurrence counter not cleared");
  edge_only_a: assert property ((q.state == S_ARM && !q.cfg.seq_mode && !ev_edge) |=>
                                !q.trig)
    else $error("edge trigger without crossing");

endmodule : tsq_sequencer
